// >>> logic/sse_pkg.sv
// Purpose: shared constants and types for the shift/store/subtract executor
// Assumes: 8-bit data and address, one system clock
// Notes: cycle counts include the three opcode fetch cycles
`default_nettype none
package sse_pkg;
  localparam int DW = 8;
  localparam int STEP_W = 3;
  localparam int FETCH_CYCLES = 3;
  localparam int CYC_W = 4;
  localparam logic [DW-1:0] RST_BYTE = 8'h00;
  localparam logic [DW-1:0] IP_STEP = 8'h01;
  localparam logic [DW-1:0] IP_TWO = 8'h02;
  localparam logic [STEP_W-1:0] STEP_ONE = 3'h1;
  localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
  // low opcode bits name the addressing mode
  localparam logic [2:0] MODE_DIR = 3'h0;
  localparam logic [2:0] MODE_IMM = 3'h6;
  localparam logic [DW-1:0] OPC_OUT_P = 8'h14;
  localparam logic [DW-1:0] OPC_SHIFT_DIR = 8'h90;
  localparam logic [DW-1:0] OPC_SHIFT_A = 8'h92;
  localparam logic [DW-1:0] OPC_SHIFT_R = 8'h93;
  localparam logic [DW-1:0] OPC_SHIFT_M = 8'h94;
  localparam logic [DW-1:0] OPC_SHIFT_I = 8'h96;
  localparam logic [DW-1:0] OPC_STOREA_DIR = 8'h50;
  localparam logic [DW-1:0] OPC_STOREA_M = 8'h54;
  localparam logic [DW-1:0] OPC_STORER_DIR = 8'h58;
  localparam logic [DW-1:0] OPC_STORER_M = 8'h5C;
  localparam logic [DW-1:0] OPC_SUB_DIR = 8'h68;
  localparam logic [DW-1:0] OPC_SUB_A = 8'h6A;
  localparam logic [DW-1:0] OPC_SUB_R = 8'h6B;
  localparam logic [DW-1:0] OPC_SUB_M = 8'h6C;
  localparam logic [DW-1:0] OPC_SUB_I = 8'h6E;
  localparam int CYC_OUT_P = 7;
  localparam int CYC_SHIFT_DIR = 11;
  localparam int CYC_SHIFT_A = 4;
  localparam int CYC_SHIFT_R = 7;
  localparam int CYC_SHIFT_M = 9;
  localparam int CYC_SHIFT_I = 8;
  localparam int CYC_ST_DIR = 9;
  localparam int CYC_ST_M = 7;
  localparam int CYC_SUB_DIR = 9;
  localparam int CYC_SUB_REG = 4;
  localparam int CYC_SUB_M = 7;
  localparam int CYC_SUB_I = 6;
  localparam int CYC_NOP = 4;

  typedef enum logic [1:0] {
    ST_FETCH_ADDR = 2'b00, ST_FETCH_DATA = 2'b01, ST_DECODE = 2'b10, ST_EXEC = 2'b11
  } sse_state_t;

  typedef enum logic [4:0] {
    U_NOP = 5'b00000, U_ARIP = 5'b00001, U_RDIP = 5'b00010, U_OR_DL = 5'b00011,
    U_OR_R = 5'b00100, U_AR_OR = 5'b00101, U_RDOP = 5'b00110, U_A_DL = 5'b00111,
    U_A_R = 5'b01000, U_SHF = 5'b01001, U_SHF_A = 5'b01010, U_A_F = 5'b01011,
    U_R_A = 5'b01100, U_SUB_DL = 5'b01101, U_SUB_A = 5'b01110, U_SUB_R = 5'b01111,
    U_WR_A = 5'b10000, U_WR_R = 5'b10001, U_WR_STB = 5'b10010, U_WR_HOLD = 5'b10011
  } sse_uop_t;

  typedef enum logic [0:0] {ALU_SHIFT = 1'b0, ALU_SUB = 1'b1} sse_alu_op_t;

  typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_STROBE = 2'b01, WR_HOLD = 2'b10} sse_wr_phase_t;

  typedef struct packed {
    sse_wr_phase_t ph;
    logic strobe;
  } sse_wr_t;

  typedef struct packed {
    logic [DW-1:0] addr;
    logic [DW-1:0] wdata;
    logic rd;
  } sse_bus_t;

  typedef struct packed {
    logic [DW-1:0] iptr;
    logic [DW-1:0] acc;
    logic [DW-1:0] sec;
  } sse_arch_t;

  typedef struct packed {
    sse_state_t st;
    logic [STEP_W-1:0] idx;
    logic [DW-1:0] ir;
    logic [DW-1:0] alat;
    logic [DW-1:0] dlat;
    logic [DW-1:0] opr;
    logic [DW-1:0] f;
    sse_arch_t arch;
    logic rd;
    logic done;
    logic go_mem;
    logic go_port;
  } sse_core_t;
endpackage : sse_pkg
`default_nettype wire

// >>> logic/sse_alu.sv
// Purpose: shift-left and subtract unit
// Assumes: a is the accumulator side, b the operand side
// Notes: purely combinational, no flags
`default_nettype none
module sse_alu (
  input wire sse_pkg::sse_alu_op_t op_i,
  input wire logic [sse_pkg::DW-1:0] a_i,
  input wire logic [sse_pkg::DW-1:0] b_i,
  output logic [sse_pkg::DW-1:0] f_o
);
  always_comb begin
    unique case (op_i)
      sse_pkg::ALU_SHIFT: f_o = {a_i[sse_pkg::DW-2:0], 1'b0};
      // wraps modulo 256, borrow is dropped
      sse_pkg::ALU_SUB: f_o = a_i - b_i;
    endcase
  end
endmodule : sse_alu
`default_nettype wire

// >>> logic/sse_wr_seq.sv
// Purpose: write strobe sequencer, setup / strobe / hold
// Assumes: start arrives with address and data already presented
// Notes: one instance for memory, one for ports
`default_nettype none
module sse_wr_seq (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic strobe_o,
  output logic busy_o
);
  sse_pkg::sse_wr_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    unique case (s_q.ph)
      sse_pkg::WR_IDLE: begin
        if (start_i) begin
          s_d.ph = sse_pkg::WR_STROBE;
          s_d.strobe = 1'b1;
        end
      end
      sse_pkg::WR_STROBE: s_d.ph = sse_pkg::WR_HOLD;
      sse_pkg::WR_HOLD: s_d.ph = sse_pkg::WR_IDLE;
      default: s_d.ph = sse_pkg::WR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{ph: sse_pkg::WR_IDLE, strobe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign strobe_o = s_q.strobe;
  assign busy_o = (s_q.ph != sse_pkg::WR_IDLE);

  a_strobe_after_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (start_i && !busy_o) |=> strobe_o ##1 !strobe_o)
    else $error("write strobe not one cycle after start");
endmodule : sse_wr_seq
`default_nettype wire

// >>> logic/sse_exec.sv
// Purpose: microcoded executor for port write, shift-left, store and subtract
// Assumes: memory answers a read within the cycle the read strobe shows; ports are only written
// Notes: bus outputs are registered and lag the micro-step by one cycle
// How it works
// - every instruction starts with a three-cycle opcode fetch, included in counts.
// - second byte: latch address from pointer, read, capture data, bump pointer.
// - direct mode moves address byte to operand latch, then address latch, reads.
// - port write: present address and data, strobe next cycle, hold one more.
// - shift-left direct 90h, two bytes, 11 cycles, memory byte shifted into accumulator.
// - left shift drops bit 7, moves bits 6..0 up, inserts zero.
// - shift-left accumulator 92h, 4 cycles, result back to accumulator.
// - shift-left second register 93h, 7 cycles, both registers get result.
// - shift-left indirect 94h, 9 cycles, reads at second register address.
// - shift-left immediate 96h, 8 cycles, data byte shifted into accumulator.
// - memory write: present, strobe next cycle, hold one more with strobe low.
// - store accumulator direct 50h, 9 cycles, pointer plus two.
// - store accumulator indirect 54h, 7 cycles, address from second register.
// - store second register direct 58h, 9 cycles, pointer plus two.
// - store second register indirect 5Ch, 7 cycles, writes itself at itself.
// - subtract direct 68h, 9 cycles, accumulator minus memory byte.
// - subtract accumulator from itself 6Ah, 4 cycles, always zero.
// - subtract second register 6Bh, 4 cycles, accumulator minus second register.
// - subtract indirect 6Ch, 7 cycles, memory at second register address.
// - subtract immediate 6Eh, 6 cycles, accumulator minus data byte.
// - subtract feeds accumulator first, operand second, result into accumulator.
`default_nettype none
module sse_exec (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [sse_pkg::DW-1:0] mem_rdata_i,
  output sse_pkg::sse_bus_t bus_o,
  output logic mem_wr_o,
  output logic port_wr_o,
  output sse_pkg::sse_arch_t arch_o,
  output logic instr_done_o
);
  ////////////////////////////////////////////////////////////////////////////
  // micro-program
  function automatic int cyc_of(input logic [sse_pkg::DW-1:0] opc);
    int n;
    n = sse_pkg::CYC_NOP;
    case (opc)
      sse_pkg::OPC_OUT_P: n = sse_pkg::CYC_OUT_P;
      sse_pkg::OPC_SHIFT_DIR: n = sse_pkg::CYC_SHIFT_DIR;
      sse_pkg::OPC_SHIFT_A: n = sse_pkg::CYC_SHIFT_A;
      sse_pkg::OPC_SHIFT_R: n = sse_pkg::CYC_SHIFT_R;
      sse_pkg::OPC_SHIFT_M: n = sse_pkg::CYC_SHIFT_M;
      sse_pkg::OPC_SHIFT_I: n = sse_pkg::CYC_SHIFT_I;
      sse_pkg::OPC_STOREA_DIR, sse_pkg::OPC_STORER_DIR: n = sse_pkg::CYC_ST_DIR;
      sse_pkg::OPC_STOREA_M, sse_pkg::OPC_STORER_M: n = sse_pkg::CYC_ST_M;
      sse_pkg::OPC_SUB_DIR: n = sse_pkg::CYC_SUB_DIR;
      sse_pkg::OPC_SUB_A, sse_pkg::OPC_SUB_R: n = sse_pkg::CYC_SUB_REG;
      sse_pkg::OPC_SUB_M: n = sse_pkg::CYC_SUB_M;
      sse_pkg::OPC_SUB_I: n = sse_pkg::CYC_SUB_I;
      default: n = sse_pkg::CYC_NOP;
    endcase
    return n;
  endfunction : cyc_of

  function automatic sse_pkg::sse_uop_t uop_at(input logic [sse_pkg::DW-1:0] opc,
                                               input logic [sse_pkg::STEP_W-1:0] idx);
    sse_pkg::sse_uop_t s [8];
    s = '{default: sse_pkg::U_NOP};
    case (opc)
      sse_pkg::OPC_OUT_P: s = '{0: sse_pkg::U_OR_R, 1: sse_pkg::U_WR_A, 2: sse_pkg::U_WR_STB,
                               3: sse_pkg::U_WR_HOLD, default: sse_pkg::U_NOP};
      sse_pkg::OPC_SHIFT_DIR: s = '{sse_pkg::U_ARIP, sse_pkg::U_RDIP, sse_pkg::U_OR_DL, sse_pkg::U_AR_OR,
                                   sse_pkg::U_RDOP, sse_pkg::U_A_DL, sse_pkg::U_SHF, sse_pkg::U_A_F};
      sse_pkg::OPC_SHIFT_A: s = '{0: sse_pkg::U_SHF_A, default: sse_pkg::U_NOP};
      sse_pkg::OPC_SHIFT_R: s = '{0: sse_pkg::U_A_R, 1: sse_pkg::U_SHF, 2: sse_pkg::U_A_F,
                                 3: sse_pkg::U_R_A, default: sse_pkg::U_NOP};
      sse_pkg::OPC_SHIFT_M: s = '{0: sse_pkg::U_OR_R, 1: sse_pkg::U_AR_OR, 2: sse_pkg::U_RDOP,
                                 3: sse_pkg::U_A_DL, 4: sse_pkg::U_SHF, 5: sse_pkg::U_A_F,
                                 default: sse_pkg::U_NOP};
      sse_pkg::OPC_SHIFT_I: s = '{0: sse_pkg::U_ARIP, 1: sse_pkg::U_RDIP, 2: sse_pkg::U_A_DL,
                                 3: sse_pkg::U_SHF, 4: sse_pkg::U_A_F, default: sse_pkg::U_NOP};
      sse_pkg::OPC_STOREA_DIR: s = '{0: sse_pkg::U_ARIP, 1: sse_pkg::U_RDIP, 2: sse_pkg::U_OR_DL,
                                    3: sse_pkg::U_WR_A, 4: sse_pkg::U_WR_STB, 5: sse_pkg::U_WR_HOLD,
                                    default: sse_pkg::U_NOP};
      sse_pkg::OPC_STOREA_M: s = '{0: sse_pkg::U_OR_R, 1: sse_pkg::U_WR_A, 2: sse_pkg::U_WR_STB,
                                  3: sse_pkg::U_WR_HOLD, default: sse_pkg::U_NOP};
      sse_pkg::OPC_STORER_DIR: s = '{0: sse_pkg::U_ARIP, 1: sse_pkg::U_RDIP, 2: sse_pkg::U_OR_DL,
                                    3: sse_pkg::U_WR_R, 4: sse_pkg::U_WR_STB, 5: sse_pkg::U_WR_HOLD,
                                    default: sse_pkg::U_NOP};
      sse_pkg::OPC_STORER_M: s = '{0: sse_pkg::U_OR_R, 1: sse_pkg::U_WR_R, 2: sse_pkg::U_WR_STB,
                                  3: sse_pkg::U_WR_HOLD, default: sse_pkg::U_NOP};
      sse_pkg::OPC_SUB_DIR: s = '{0: sse_pkg::U_ARIP, 1: sse_pkg::U_RDIP, 2: sse_pkg::U_OR_DL,
                                 3: sse_pkg::U_AR_OR, 4: sse_pkg::U_RDOP, 5: sse_pkg::U_SUB_DL,
                                 default: sse_pkg::U_NOP};
      sse_pkg::OPC_SUB_A: s = '{0: sse_pkg::U_SUB_A, default: sse_pkg::U_NOP};
      sse_pkg::OPC_SUB_R: s = '{0: sse_pkg::U_SUB_R, default: sse_pkg::U_NOP};
      sse_pkg::OPC_SUB_M: s = '{0: sse_pkg::U_OR_R, 1: sse_pkg::U_AR_OR, 2: sse_pkg::U_RDOP,
                               3: sse_pkg::U_SUB_DL, default: sse_pkg::U_NOP};
      sse_pkg::OPC_SUB_I: s = '{0: sse_pkg::U_ARIP, 1: sse_pkg::U_RDIP, 2: sse_pkg::U_SUB_DL,
                               default: sse_pkg::U_NOP};
      // opcodes outside this group run as a one-step no-op
      default: s = '{default: sse_pkg::U_NOP};
    endcase
    return s[idx];
  endfunction : uop_at

  ////////////////////////////////////////////////////////////////////////////
  // datapath and sequencer
  sse_pkg::sse_core_t s_q, s_d;
  sse_pkg::sse_uop_t uop;
  logic last;
  sse_pkg::sse_alu_op_t alu_op;
  logic [sse_pkg::DW-1:0] alu_b;
  logic [sse_pkg::DW-1:0] alu_f;

  always_comb begin
    uop = uop_at(s_q.ir, s_q.idx);
    last = (s_q.idx == sse_pkg::STEP_W'(cyc_of(s_q.ir) - sse_pkg::FETCH_CYCLES - 1));
    alu_op = sse_pkg::ALU_SUB;
    alu_b = s_q.dlat;
    unique case (uop)
      sse_pkg::U_SHF, sse_pkg::U_SHF_A: alu_op = sse_pkg::ALU_SHIFT;
      sse_pkg::U_SUB_A: alu_b = s_q.arch.acc;
      sse_pkg::U_SUB_R: alu_b = s_q.arch.sec;
      default: alu_b = s_q.dlat;
    endcase
  end

  sse_alu u_alu (
    .op_i(alu_op),
    .a_i(s_q.arch.acc),
    .b_i(alu_b),
    .f_o(alu_f)
  );

  always_comb begin
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.done = 1'b0;
    s_d.go_mem = 1'b0;
    s_d.go_port = 1'b0;
    unique case (s_q.st)
      sse_pkg::ST_FETCH_ADDR: begin
        s_d.alat = s_q.arch.iptr;
        s_d.rd = 1'b1;
        s_d.st = sse_pkg::ST_FETCH_DATA;
      end
      sse_pkg::ST_FETCH_DATA: begin
        s_d.dlat = mem_rdata_i;
        s_d.arch.iptr = s_q.arch.iptr + sse_pkg::IP_STEP;
        s_d.rd = 1'b1;
        s_d.st = sse_pkg::ST_DECODE;
      end
      sse_pkg::ST_DECODE: begin
        s_d.ir = s_q.dlat;
        s_d.idx = '0;
        s_d.st = sse_pkg::ST_EXEC;
      end
      sse_pkg::ST_EXEC: begin
        unique case (uop)
          sse_pkg::U_ARIP: begin
            s_d.alat = s_q.arch.iptr;
            s_d.rd = 1'b1;
          end
          sse_pkg::U_RDIP: begin
            s_d.dlat = mem_rdata_i;
            s_d.arch.iptr = s_q.arch.iptr + sse_pkg::IP_STEP;
            s_d.rd = 1'b1;
          end
          sse_pkg::U_OR_DL: s_d.opr = s_q.dlat;
          sse_pkg::U_OR_R: s_d.opr = s_q.arch.sec;
          sse_pkg::U_AR_OR: begin
            s_d.alat = s_q.opr;
            s_d.rd = 1'b1;
          end
          sse_pkg::U_RDOP: begin
            s_d.dlat = mem_rdata_i;
            s_d.rd = 1'b1;
          end
          sse_pkg::U_A_DL: s_d.arch.acc = s_q.dlat;
          sse_pkg::U_A_R: s_d.arch.acc = s_q.arch.sec;
          sse_pkg::U_SHF: s_d.f = alu_f;
          sse_pkg::U_A_F: s_d.arch.acc = s_q.f;
          sse_pkg::U_R_A: s_d.arch.sec = s_q.arch.acc;
          sse_pkg::U_SHF_A, sse_pkg::U_SUB_DL, sse_pkg::U_SUB_A, sse_pkg::U_SUB_R: begin
            s_d.arch.acc = alu_f;
          end
          sse_pkg::U_WR_A, sse_pkg::U_WR_R: begin
            s_d.alat = s_q.opr;
            s_d.dlat = (uop == sse_pkg::U_WR_A) ? s_q.arch.acc : s_q.arch.sec;
            // the one write opcode of this group aimed at a port
            s_d.go_port = (s_q.ir == sse_pkg::OPC_OUT_P);
            s_d.go_mem = (s_q.ir != sse_pkg::OPC_OUT_P);
          end
          default: s_d.f = s_q.f;
        endcase
        if (last) begin
          s_d.st = sse_pkg::ST_FETCH_ADDR;
          s_d.done = 1'b1;
        end else begin
          s_d.idx = s_q.idx + sse_pkg::STEP_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: sse_pkg::ST_FETCH_ADDR, idx: '0, ir: sse_pkg::RST_BYTE, alat: sse_pkg::RST_BYTE,
               dlat: sse_pkg::RST_BYTE, opr: sse_pkg::RST_BYTE, f: sse_pkg::RST_BYTE,
               arch: '{iptr: sse_pkg::RST_BYTE, acc: sse_pkg::RST_BYTE, sec: sse_pkg::RST_BYTE},
               rd: 1'b0, done: 1'b0, go_mem: 1'b0, go_port: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write strobes; address and data stay put in the latches through the hold
  sse_wr_seq u_mem_wr (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(s_q.go_mem),
    .strobe_o(mem_wr_o),
    .busy_o()
  );

  sse_wr_seq u_port_wr (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(s_q.go_port),
    .strobe_o(port_wr_o),
    .busy_o()
  );

  assign bus_o = '{addr: s_q.alat, wdata: s_q.dlat, rd: s_q.rd};
  assign arch_o = s_q.arch;
  assign instr_done_o = s_q.done;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [sse_pkg::CYC_W-1:0] cyc_q;
  logic [sse_pkg::DW-1:0] ip_start_q;
  logic exec_c;
  logic two_byte;

  assign exec_c = (s_q.st == sse_pkg::ST_EXEC);
  assign two_byte = (cyc_of(s_q.ir) != sse_pkg::CYC_NOP || s_q.ir == sse_pkg::OPC_SUB_A
                     || s_q.ir == sse_pkg::OPC_SUB_R)
                    && (s_q.ir[2:0] == sse_pkg::MODE_DIR || s_q.ir[2:0] == sse_pkg::MODE_IMM);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_q <= '0;
      ip_start_q <= sse_pkg::RST_BYTE;
    end else begin
      cyc_q <= (s_q.st == sse_pkg::ST_FETCH_ADDR) ? sse_pkg::CYC_ONE : cyc_q + sse_pkg::CYC_ONE;
      if (s_q.st == sse_pkg::ST_FETCH_ADDR) begin
        ip_start_q <= s_q.arch.iptr;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_fetch_three_cyc: assert property ((exec_c && s_q.idx == '0) |->
    $past(s_q.st, 3) == sse_pkg::ST_FETCH_ADDR && $past(s_q.st) == sse_pkg::ST_DECODE)
    else $error("execution began without a three-cycle fetch");
  a_instr_cycle_count: assert property ((exec_c && last) |-> int'(cyc_q) == cyc_of(s_q.ir) - 1)
    else $error("instruction length in cycles wrong");
  a_fetch_read_ip: assert property ((s_q.st == sse_pkg::ST_FETCH_DATA) |->
    (bus_o.rd && bus_o.addr == s_q.arch.iptr) ##1 s_q.arch.iptr == $past(s_q.arch.iptr) + sse_pkg::IP_STEP)
    else $error("fetch read or pointer increment wrong");
  a_direct_addr_read: assert property ((exec_c && uop == sse_pkg::U_AR_OR) |=>
    bus_o.rd && bus_o.addr == $past(s_q.opr))
    else $error("operand address not driven with read strobe");
  a_mem_wr_window: assert property (mem_wr_o |->
    ($stable(bus_o.addr) && $stable(bus_o.wdata) && !bus_o.rd)
    ##1 (!mem_wr_o && $stable(bus_o.addr) && $stable(bus_o.wdata)))
    else $error("memory write setup, strobe or hold broken");
  a_port_wr_window: assert property (port_wr_o |->
    ($stable(bus_o.addr) && $stable(bus_o.wdata) && !mem_wr_o)
    ##1 (!port_wr_o && $stable(bus_o.addr) && $stable(bus_o.wdata)))
    else $error("port write setup, strobe or hold broken");
  a_shl_acc_bits: assert property ((exec_c && uop == sse_pkg::U_SHF_A) |=>
    arch_o.acc == {$past(s_q.arch.acc[sse_pkg::DW-2:0]), 1'b0})
    else $error("left shift result wrong");
  a_shl_both_regs: assert property ((exec_c && uop == sse_pkg::U_R_A) |=>
    arch_o.sec == arch_o.acc)
    else $error("second register does not match accumulator");
  a_sub_difference: assert property ((exec_c && uop == sse_pkg::U_SUB_DL) |=>
    arch_o.acc == sse_pkg::DW'($past(s_q.arch.acc) - $past(s_q.dlat)))
    else $error("subtract result wrong");
  a_sub_self_zero: assert property ((exec_c && uop == sse_pkg::U_SUB_A) |=> arch_o.acc == '0)
    else $error("self subtract not zero");
  a_ip_advance_len: assert property ((exec_c && last) |=>
    arch_o.iptr == ip_start_q + (two_byte ? sse_pkg::IP_TWO : sse_pkg::IP_STEP))
    else $error("pointer advance wrong");

  c_shift_direct: cover property (exec_c && last && s_q.ir == sse_pkg::OPC_SHIFT_DIR);
  c_mem_write: cover property ($rose(mem_wr_o));
  c_port_write: cover property ($rose(port_wr_o));
  c_sub_imm: cover property (exec_c && last && s_q.ir == sse_pkg::OPC_SUB_I);
endmodule : sse_exec
`default_nettype wire

// >>> bench/sse_mem_model.sv
// Purpose: memory and port space on the far side of the executor bus
// Assumes: zero wait states, a read is answered in the cycle that rd shows
// Notes: a released read line shows the inverted last byte, never a held one
`default_nettype none
module sse_mem_model (
  input wire logic clk_i,
  input wire sse_pkg::sse_bus_t bus_i,
  input wire logic mem_wr_i,
  input wire logic port_wr_i,
  output logic [sse_pkg::DW-1:0] rdata_o,
  output logic [sse_pkg::DW-1:0] port_addr_o,
  output logic [sse_pkg::DW-1:0] port_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  // inverted byte when idle so a stale value can never pass for a real answer
  assign rdata_o = bus_i.rd ? mem[bus_i.addr] : ~last_q;
  always @(posedge clk_i) begin
    if (bus_i.rd) last_q <= mem[bus_i.addr];
    if (mem_wr_i) mem[bus_i.addr] <= bus_i.wdata;
    if (port_wr_i) begin
      port_addr_o <= bus_i.addr;
      port_data_o <= bus_i.wdata;
    end
  end
endmodule : sse_mem_model
`default_nettype wire

// >>> bench/tb_shift_store_subtract_exec.sv
// Purpose: self-checking bench for the shift/store/subtract executor
// Assumes: program and data share one random 256-byte memory
// Notes: two passes from reset, so a reset in mid-run is covered too
`default_nettype none
module tb_shift_store_subtract_exec;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N_INSTR = 200;
  // last entry stands for every unknown opcode
  localparam logic [7:0] OPS [16] = '{8'h14, 8'h90, 8'h92, 8'h93, 8'h94, 8'h96, 8'h50, 8'h54,
    8'h58, 8'h5C, 8'h68, 8'h6A, 8'h6B, 8'h6C, 8'h6E, 8'h00};
  localparam int CYC [16] = '{7, 11, 4, 7, 9, 8, 9, 7, 9, 7, 9, 4, 4, 7, 6, 4};
  localparam int LEN [16] = '{1, 2, 1, 1, 1, 2, 2, 1, 2, 1, 2, 1, 1, 1, 2, 1};
  logic clk;
  logic rst_n;
  logic [7:0] rdata, port_addr, port_data;
  logic mem_wr, port_wr, done;
  logic [17:0] h0, h1, cur;
  sse_pkg::sse_bus_t bus;
  sse_pkg::sse_arch_t arch;
  int checks = 0;
  int miscompares = 0;
  int seed = 40303;
  int ra, rs, rip;
  int rm [256];

  sse_exec dut (.clk_i(clk), .rst_n_i(rst_n), .mem_rdata_i(rdata), .bus_o(bus), .mem_wr_o(mem_wr),
    .port_wr_o(port_wr), .arch_o(arch), .instr_done_o(done));
  sse_mem_model mdl (.clk_i(clk), .bus_i(bus), .mem_wr_i(mem_wr), .port_wr_i(port_wr), .rdata_o(rdata),
    .port_addr_o(port_addr), .port_data_o(port_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // reference executor on integers, wrapping by masking
  task automatic ref_step(output int cyc);
    int op;
    int b2;
    int j;
    op = rm[rip];
    b2 = rm[(rip + 1) & 255];
    j = 15;
    for (int i = 0; i < 15; i++) if (OPS[i] == op) j = i;
    case (op)
      'h90: ra = rm[b2] << 1;
      'h92: ra = ra << 1;
      'h93: ra = rs << 1;
      'h94: ra = rm[rs] << 1;
      'h96: ra = b2 << 1;
      'h50: rm[b2] = ra;
      'h54: rm[rs] = ra;
      'h58: rm[b2] = rs;
      'h5C: rm[rs] = rs;
      'h68: ra = ra - rm[b2];
      'h6A: ra = ra - ra;
      'h6B: ra = ra - rs;
      'h6C: ra = ra - rm[rs];
      'h6E: ra = ra - b2;
      default: ;
    endcase
    ra = ra & 255;
    if (op == 'h93) rs = ra;
    rip = (rip + LEN[j]) & 255;
    cyc = CYC[j];
  endtask : ref_step

  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 40);
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////
  // write window on the wire: setup, strobe, hold with the same address and data
  always @(posedge clk) begin
    cur = {mem_wr | port_wr, bus};
    if (!rst_n) begin
      h0 <= '0;
      h1 <= '0;
    end else begin
      if (h0[17]) begin
        check("wr_strobe", {cur[17], h1[17], h0[0]}, 16'h0000);
        check("wr_hold", cur[16:1], h0[16:1]);
        check("wr_setup", h1[16:1], h0[16:1]);
      end
      h1 <= h0;
      h0 <= cur;
    end
  end

  initial begin
    int v, n, cyc, op;
    rst_n = 1'b0;
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clk);
      #1 rst_n = 1'b0;
      for (int i = 0; i < 256; i++) begin
        v = $random(seed);
        rm[i] = (v[5:4] != 2'b00) ? OPS[v[3:0]] : v[15:8];
        mdl.mem[i] = 8'(rm[i]);
      end
      ra = 0;
      rs = 0;
      rip = 0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int k = 0; k < N_INSTR; k++) begin
        op = rm[rip];
        ref_step(cyc);
        wait_done(n);
        check("cycles", 16'(n), 16'(cyc));
        check("ip", arch.iptr, 16'(rip));
        check("acc", arch.acc, 16'(ra));
        check("sec", arch.sec, 16'(rs));
        if (op == 'h14) check("port", {port_addr, port_data}, {8'(rs), 8'(ra)});
      end
      for (int i = 0; i < 256; i++) check("mem", mdl.mem[i], 16'(rm[i]));
    end
    tally_and_finish();
  end

  initial begin
    #80000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_shift_store_subtract_exec
`default_nettype wire
